/* dv/tb_pdcfg_top.sv */
// Self-checking bench for the pad threshold and output drive bank
module tb_pdcfg_top;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////
  // Design signals, all inputs but presetn valued at time zero
  logic pclk = 1'b0;
  logic presetn;
  logic [17:0] paddr = 18'h00000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] port2_hyst;
  logic [15:0] port3_hyst;
  logic [7:0] port4_hyst;
  logic [7:0] port7_hyst;
  logic [7:0] port8_hyst;
  logic [47:0] pad_edge_rate;
  logic [47:0] pad_drive;
  int n_errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic err;
  logic [15:0] w;
  logic [47:0] exp_e;
  logic [47:0] exp_d;
  int k;

  // Free-running 250 MHz clock
  always #2 pclk = ~pclk;

  pdcfg_top #(.ADDR_W(18)) i_pdcfg_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port2_hyst(port2_hyst), .port3_hyst(port3_hyst),
    .port4_hyst(port4_hyst), .port7_hyst(port7_hyst), .port8_hyst(port8_hyst),
    .pad_edge_rate(pad_edge_rate), .pad_drive(pad_drive)
  );

  ////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or a bus timeout
  task automatic summarize();
    $display("errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compare up to 48 bits, zero-extended
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Byte address is four times the register index
  function automatic logic [17:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // One APB transfer; the upper write lanes carry ones so ignoring them shows
  task automatic apb(input logic wr, input logic [17:0] a, input logic [15:0] wd,
                     output logic [31:0] rdat, output logic perr);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'hFFFF, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      $display("mismatch at %0t: no ready answer", $time);
      summarize();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    // Reset falls from unknown so the asynchronous clear really fires
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < pdcfg_pkg::OC_CNT; i++) begin
      apb(1'b0, ba(pdcfg_pkg::OC_IDX[i]), 16'h0000, rd, err);
      chk({16'h0000, rd}, 48'h0, "control reset");
    end
    apb(1'b0, ba(pdcfg_pkg::IDX_THR), 16'h0000, rd, err);
    chk({16'h0000, rd}, 48'h0, "threshold reset");
    chk(pad_edge_rate | pad_drive, 48'h0, "pads after reset");
    // fields fan out per nibble, every edge and drive code used
    exp_e = '0;
    exp_d = '0;
    w = 16'h1E4B;
    for (int i = 0; i < pdcfg_pkg::OC_CNT; i++) begin
      apb(1'b1, ba(pdcfg_pkg::OC_IDX[i]), w, rd, err);
      chk({47'h0, err}, 48'h0, "write error flag");
      apb(1'b0, ba(pdcfg_pkg::OC_IDX[i]), 16'h0000, rd, err);
      chk({16'h0000, rd}, {32'h0, (pdcfg_pkg::OC_NIBS[i] == 4) ? w : {8'h00, w[7:0]}},
          "control readback");
      for (int j = 0; j < pdcfg_pkg::OC_NIBS[i]; j++) begin
        k = pdcfg_pkg::OC_BASE[i] + j;
        exp_e[2*k +: 2] = w[4*j +: 2];
        exp_d[2*k +: 2] = w[4*j+2 +: 2];
      end
      w = w + 16'h1111;
    end
    @(negedge pclk);
    chk(pad_edge_rate, exp_e, "edge rate pads");
    chk(pad_drive, exp_d, "drive pads");
    // walk each select bit, then all ones
    for (int b = 0; b <= 8; b++) begin
      w = (b == 8) ? 16'hFFFF : (16'h0001 << b);
      apb(1'b1, ba(pdcfg_pkg::IDX_THR), w, rd, err);
      apb(1'b0, ba(pdcfg_pkg::IDX_THR), 16'h0000, rd, err);
      chk({16'h0000, rd}, {32'h0, w & 16'h00DF}, "threshold readback");
      @(negedge pclk);
      chk({32'h0, port2_hyst}, {32'h0, {8{w[1]}}, {8{w[0]}}}, "port2 select");
      chk({32'h0, port3_hyst}, {32'h0, {8{w[3]}}, {8{w[2]}}}, "port3 select");
      chk({24'h0, port4_hyst, port7_hyst, port8_hyst},
          {24'h0, {8{w[4]}}, {8{w[6]}}, {8{w[7]}}}, "byte selects");
      chk(pad_edge_rate ^ exp_e | pad_drive ^ exp_d, 48'h0, "pads kept");
    end
    // slow edge on port 0 low nibble 0, then left alone
    apb(1'b1, ba(pdcfg_pkg::IDX_P0L_DRV), 16'h0001, rd, err);
    exp_e[3:0] = 4'h1;
    exp_d[3:0] = 4'h0;
    apb(1'b0, ba(pdcfg_pkg::IDX_P0L_DRV), 16'h0000, rd, err);
    chk({16'h0000, rd}, 48'h1, "slow edge readback");
    @(negedge pclk);
    chk(pad_edge_rate ^ exp_e | pad_drive ^ exp_d, 48'h0, "slow edge pads");
    // Unmapped and unaligned accesses are refused and change nothing
    apb(1'b1, ba(16'hF094), 16'hFFFF, rd, err);
    chk({47'h0, err}, 48'h1, "unmapped write flag");
    apb(1'b0, ba(16'hF094), 16'h0000, rd, err);
    chk({15'h0, err, rd}, 48'h1_0000_0000, "unmapped read");
    apb(1'b1, ba(pdcfg_pkg::IDX_P2_DRV) | 18'h00001, 16'h0000, rd, err);
    chk({47'h0, err}, 48'h1, "unaligned write flag");
    @(negedge pclk);
    chk(pad_edge_rate ^ exp_e | pad_drive ^ exp_d, 48'h0, "pads after refused writes");
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk(pad_edge_rate | pad_drive, 48'h0, "pads in reset");
    chk({16'h0, port2_hyst | port3_hyst}, 48'h0, "selects in reset");
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ba(pdcfg_pkg::IDX_P3_DRV), 16'h0000, rd, err);
    chk({16'h0000, rd}, 48'h0, "control after reset");
    summarize();
  end

endmodule // tb_pdcfg_top

/* rtl/pdcfg_ocon_reg.sv */
// One pad output control register with per-nibble edge and drive fields
module pdcfg_ocon_reg #(
  parameter int NIB = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  // Read value and pad controls
  output logic [15:0] rdata,
  output logic [2*NIB-1:0] edge_rate,
  output logic [2*NIB-1:0] drive
);

  logic [4*NIB-1:0] oc_q;
  logic [4*NIB-1:0] oc_d;

  // Codes are stored as written; reserved codes are software's to avoid
  // edge codes kept
  assign oc_d = wr_en ? wdata[4*NIB-1:0] : oc_q;

  // Bits above the implemented nibbles read as zero
  // high byte zero when NIB is 2
  assign rdata = 16'(oc_q);

  // Storage, cleared to fast edges and full drive
  // clear on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_q <= pdcfg_pkg::OC_RESET[4*NIB-1:0];
    end else begin
      oc_q <= oc_d;
    end
  end

  // Split each nibble into its two fields
  // edge low, drive high
  for (genvar n = 0; n < NIB; n++) begin : g_nib
    assign edge_rate[2*n +: 2] = oc_q[pdcfg_pkg::NIB_W*n + pdcfg_pkg::EC_LSB +: 2];
    assign drive[2*n +: 2] = oc_q[pdcfg_pkg::NIB_W*n + pdcfg_pkg::DC_LSB +: 2];
  end

endmodule // pdcfg_ocon_reg

/* rtl/pdcfg_pkg.sv */
// Constants for the pad threshold and output drive configuration bank
package pdcfg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register indices; byte address on APB is four times the index
  localparam logic [15:0] IDX_P0L_DRV = 16'hF080;
  localparam logic [15:0] IDX_P0H_DRV = 16'hF082;
  localparam logic [15:0] IDX_P1L_DRV = 16'hF084;
  localparam logic [15:0] IDX_P1H_DRV = 16'hF086;
  localparam logic [15:0] IDX_P2_DRV = 16'hF088;
  localparam logic [15:0] IDX_P3_DRV = 16'hF08A;
  localparam logic [15:0] IDX_P4_DRV = 16'hF08C;
  localparam logic [15:0] IDX_P6_DRV = 16'hF08E;
  localparam logic [15:0] IDX_P7_DRV = 16'hF090;
  localparam logic [15:0] IDX_P8_DRV = 16'hF092;
  localparam logic [15:0] IDX_THR = 16'hF1C4;

  ////////////////////////////////////////////////////////////////////////
  // Output control register table, in index order
  localparam int OC_CNT = 10;
  localparam int NIB_TOTAL = 24;
  localparam logic [15:0] OC_IDX [OC_CNT] = '{IDX_P0L_DRV, IDX_P0H_DRV,
    IDX_P1L_DRV, IDX_P1H_DRV, IDX_P2_DRV, IDX_P3_DRV, IDX_P4_DRV,
    IDX_P6_DRV, IDX_P7_DRV, IDX_P8_DRV};
  localparam int OC_NIBS [OC_CNT] = '{2, 2, 2, 2, 4, 4, 2, 2, 2, 2};
  localparam int OC_BASE [OC_CNT] = '{0, 2, 4, 6, 8, 12, 16, 18, 20, 22};

  ////////////////////////////////////////////////////////////////////////
  // Nibble field layout
  localparam int NIB_W = 4;
  localparam int EC_LSB = 0;
  localparam int DC_LSB = 2;
  localparam logic [15:0] OC_RESET = 16'h0000;

  // Edge rate and drive strength codes
  localparam logic [1:0] EC_FAST = 2'h0;
  localparam logic [1:0] EC_SLOW = 2'h1;
  localparam logic [1:0] DC_HIGH = 2'h0;
  localparam logic [1:0] DC_DYN = 2'h1;
  localparam logic [1:0] DC_LOW = 2'h2;

  // Nominal slow edge time and its length in pclk cycles
  localparam int SLOW_EDGE_NS = 60;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SLOW_EDGE_CYC = SLOW_EDGE_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////
  // Threshold register bit positions and mask
  localparam int TH_P2L = 0;
  localparam int TH_P2H = 1;
  localparam int TH_P3L = 2;
  localparam int TH_P3H = 3;
  localparam int TH_P4L = 4;
  localparam int TH_P7L = 6;
  localparam int TH_P8L = 7;
  localparam logic [15:0] TH_MASK = 16'h00DF;
  localparam logic [15:0] TH_RESET = 16'h0000;

endpackage

/* rtl/pdcfg_thr_reg.sv */
// Input threshold select register
module pdcfg_thr_reg (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  // Stored value
  output logic [15:0] thr_q
);

  logic [15:0] thr_d;

  // Unimplemented bits are masked off so they always read zero
  // unimplemented bits zero
  assign thr_d = wr_en ? (wdata & pdcfg_pkg::TH_MASK) : thr_q;

  // Storage, cleared to standard thresholds
  // clear on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q <= pdcfg_pkg::TH_RESET;
    end else begin
      thr_q <= thr_d;
    end
  end

endmodule // pdcfg_thr_reg

/* rtl/pdcfg_top.sv */
// APB register bank for pad input thresholds and output drive settings
//
// Notes on behaviour
// - Set bit selects hysteresis for eight pins
// - One bit per byte of ports
// - Threshold never touches direction or output mode
// - Four pads share one edge rate
// - Four pads share one drive strength
// - Edge codes fast, slow; others reserved
// - Drive codes full, dynamic, reduced; 11 reserved
// - Edge low pair, drive high pair
// - Eight-bit port registers read high byte zero
// - Ports 2, 3 four nibbles, others two
module pdcfg_top #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Per-pin input threshold selects, high means hysteresis
  output logic [15:0] port2_hyst,
  output logic [15:0] port3_hyst,
  output logic [7:0] port4_hyst,
  output logic [7:0] port7_hyst,
  output logic [7:0] port8_hyst,
  // Per-nibble pad controls, two bits per nibble
  output logic [2*pdcfg_pkg::NIB_TOTAL-1:0] pad_edge_rate,
  output logic [2*pdcfg_pkg::NIB_TOTAL-1:0] pad_drive
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [15:0] reg_idx;
  logic aligned;
  logic setup_ph;
  logic wr_fire;
  logic thr_hit;
  logic thr_wr;
  logic [pdcfg_pkg::OC_CNT-1:0] oc_hit;
  logic [pdcfg_pkg::OC_CNT-1:0] oc_we;
  logic [15:0] oc_rd [pdcfg_pkg::OC_CNT];
  logic [15:0] rd_chain [pdcfg_pkg::OC_CNT+1];
  logic mapped;
  logic [15:0] rd_word;
  logic [15:0] thr_q;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Word index; sub-word addresses are refused rather than aliased
  assign reg_idx = 16'(paddr[ADDR_W-1:2]);
  assign aligned = (paddr[1:0] == 2'h0);

  // Setup cycle and the access edge at which writes land
  assign setup_ph = psel & ~penable;
  assign wr_fire = psel & penable & pready_q & pwrite;

  // Threshold register select
  assign thr_hit = aligned & (reg_idx == pdcfg_pkg::IDX_THR);
  assign thr_wr = wr_fire & thr_hit;

  ////////////////////////////////////////////////////////////////////////
  // Input threshold register

  pdcfg_thr_reg u_thr (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(thr_wr),
    .wdata(pwdata[15:0]),
    .thr_q(thr_q)
  );

  assign port2_hyst = {{8{thr_q[pdcfg_pkg::TH_P2H]}}, {8{thr_q[pdcfg_pkg::TH_P2L]}}};
  assign port3_hyst = {{8{thr_q[pdcfg_pkg::TH_P3H]}}, {8{thr_q[pdcfg_pkg::TH_P3L]}}};
  assign port4_hyst = {8{thr_q[pdcfg_pkg::TH_P4L]}};
  assign port7_hyst = {8{thr_q[pdcfg_pkg::TH_P7L]}};
  assign port8_hyst = {8{thr_q[pdcfg_pkg::TH_P8L]}};

  // threshold stays input-only
  // The threshold selects go only to the input buffers; direction and
  // output mode logic elsewhere never sees them, so every combination works.

  ////////////////////////////////////////////////////////////////////////
  // Output control registers

  for (genvar g = 0; g < pdcfg_pkg::OC_CNT; g++) begin : g_oc
    assign oc_hit[g] = aligned & (reg_idx == pdcfg_pkg::OC_IDX[g]);
    assign oc_we[g] = wr_fire & oc_hit[g];

    pdcfg_ocon_reg #(
      .NIB(pdcfg_pkg::OC_NIBS[g])
    ) u_oc (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(oc_we[g]),
      .wdata(pwdata[15:0]),
      .rdata(oc_rd[g]),
      .edge_rate(pad_edge_rate[2*pdcfg_pkg::OC_BASE[g] +: 2*pdcfg_pkg::OC_NIBS[g]]),
      .drive(pad_drive[2*pdcfg_pkg::OC_BASE[g] +: 2*pdcfg_pkg::OC_NIBS[g]])
    );

    // AND-OR read mux; at most one select is high
    assign rd_chain[g+1] = rd_chain[g] | (oc_hit[g] ? oc_rd[g] : 16'h0000);
  end

  assign rd_chain[0] = thr_hit ? thr_q : 16'h0000;
  assign rd_word = rd_chain[pdcfg_pkg::OC_CNT];
  assign mapped = thr_hit | (|oc_hit);

  ////////////////////////////////////////////////////////////////////////
  // APB answer

  // The answer is built in the setup cycle so that pready, prdata and
  // pslverr all leave flip-flops; the cost is one access cycle, never more.
  assign pready_d = setup_ph;
  assign pslverr_d = setup_ph & ~mapped;
  assign prdata_d = (setup_ph & mapped & ~pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;

  // Answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Low byte of port 2 follows its select bit
  property p_thr_p2_low;
    @(posedge pclk) disable iff (!presetn)
    thr_wr |=> (port2_hyst[7:0] == {8{$past(pwdata[0])}});
  endproperty
  a_thr_p2_low: assert property (p_thr_p2_low)
    else $error("port 2 low byte threshold did not follow write");

  // Whole-byte ports and the port 3 high byte follow their own bits
  property p_thr_bytes;
    @(posedge pclk) disable iff (!presetn)
    thr_wr |=> (port4_hyst == {8{$past(pwdata[4])}})
      && (port7_hyst == {8{$past(pwdata[6])}})
      && (port8_hyst == {8{$past(pwdata[7])}})
      && (port3_hyst[15:8] == {8{$past(pwdata[3])}});
  endproperty
  a_thr_bytes: assert property (p_thr_bytes)
    else $error("byte threshold selects wrong after write");

  // A threshold write leaves every pad output setting untouched
  property p_thr_isolated;
    @(posedge pclk) disable iff (!presetn)
    thr_wr |=> $stable(pad_edge_rate) && $stable(pad_drive);
  endproperty
  a_thr_isolated: assert property (p_thr_isolated)
    else $error("threshold write disturbed output pad settings");

  // Port 2 nibble 0 edge field taken from bits 1:0
  property p_edge_p2;
    @(posedge pclk) disable iff (!presetn)
    oc_we[4] |=> (pad_edge_rate[17:16] == $past(pwdata[1:0]));
  endproperty
  a_edge_p2: assert property (p_edge_p2)
    else $error("port 2 nibble 0 edge rate wrong");

  // Port 2 nibble 0 drive field taken from bits 3:2
  property p_drive_p2;
    @(posedge pclk) disable iff (!presetn)
    oc_we[4] |=> (pad_drive[17:16] == $past(pwdata[3:2]));
  endproperty
  a_drive_p2: assert property (p_drive_p2)
    else $error("port 2 nibble 0 drive strength wrong");

  // Slow edge code reaches the pad and holds without writes
  property p_edge_slow;
    @(posedge pclk) disable iff (!presetn)
    (oc_we[0] && pwdata[1:0] == pdcfg_pkg::EC_SLOW) ##1 !oc_we[0]
      |=> (pad_edge_rate[1:0] == pdcfg_pkg::EC_SLOW);
  endproperty
  a_edge_slow: assert property (p_edge_slow)
    else $error("slow edge code lost on port 0 low nibble 0");

  // Reduced drive code reaches the pad
  property p_drive_low;
    @(posedge pclk) disable iff (!presetn)
    (oc_we[0] && pwdata[3:2] == pdcfg_pkg::DC_LOW)
      |=> (pad_drive[1:0] == pdcfg_pkg::DC_LOW);
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("reduced drive code not applied");

  // Read-back packs edge low, drive high in each nibble
  property p_read_layout;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && oc_hit[4]) |=>
      (prdata[15:0] == {pad_drive[23:22], pad_edge_rate[23:22],
                        pad_drive[21:20], pad_edge_rate[21:20],
                        pad_drive[19:18], pad_edge_rate[19:18],
                        pad_drive[17:16], pad_edge_rate[17:16]});
  endproperty
  a_read_layout: assert property (p_read_layout)
    else $error("port 2 read-back layout wrong");

  // Eight-bit port register reads zero in the high byte
  property p_read_hi_zero;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && (oc_hit[6] || oc_hit[9])) |=> (prdata[31:8] == 24'h000000);
  endproperty
  a_read_hi_zero: assert property (p_read_hi_zero)
    else $error("eight-bit port register high byte not zero");

  // Port 3 nibble 3 is stored in full
  property p_p3_nib3;
    @(posedge pclk) disable iff (!presetn)
    oc_we[5] |=> (pad_edge_rate[31:30] == $past(pwdata[13:12]))
      && (pad_drive[31:30] == $past(pwdata[15:14]));
  endproperty
  a_p3_nib3: assert property (p_p3_nib3)
    else $error("port 3 nibble 3 not controlled");

  // All settings are zero right after reset release
  property p_reset_zero;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (pad_edge_rate == '0) && (pad_drive == '0) && (thr_q == 16'h0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("settings not cleared by reset");

  // Every setup cycle is answered in the next cycle only
  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    setup_ph |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not a single cycle after setup");

  // Fast edge code on port 3 nibble 0 reaches the pad
  property p_edge_fast;
    @(posedge pclk) disable iff (!presetn)
    (oc_we[5] && pwdata[1:0] == pdcfg_pkg::EC_FAST)
      |=> (pad_edge_rate[25:24] == pdcfg_pkg::EC_FAST);
  endproperty
  a_edge_fast: assert property (p_edge_fast)
    else $error("fast edge code not applied on port 3 nibble 0");

  // Dynamic drive code on port 8 nibble 0 reaches the pad
  property p_drive_dyn;
    @(posedge pclk) disable iff (!presetn)
    (oc_we[9] && pwdata[3:2] == pdcfg_pkg::DC_DYN)
      |=> (pad_drive[45:44] == pdcfg_pkg::DC_DYN);
  endproperty
  a_drive_dyn: assert property (p_drive_dyn)
    else $error("dynamic drive code not applied on port 8 nibble 0");

  // Unimplemented threshold bits read as zero
  property p_thr_read_mask;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && thr_hit) |=> (prdata[15:8] == 8'h00) && !prdata[5];
  endproperty
  a_thr_read_mask: assert property (p_thr_read_mask)
    else $error("unimplemented threshold bits read nonzero");

  // A refused write leaves every setting untouched
  property p_refused_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && !mapped)
      |=> $stable(pad_edge_rate) && $stable(pad_drive) && $stable(thr_q);
  endproperty
  a_refused_write: assert property (p_refused_write)
    else $error("refused write changed a setting");

  // Read data stays at zero outside the answer cycle
  property p_rdata_idle;
    @(posedge pclk) disable iff (!presetn)
    !pready |-> (prdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside answer");

endmodule // pdcfg_top
